// ==== src/fpdv_top.sv ====
// Single-precision divide sequencer with an AXI4-Lite register file.
// Assumes one clock, synchronous active-low reset, and a master that
// keeps one write and one read outstanding at most.
`timescale 1ns/1ps

module fpdv_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire fpdv_pkg::fpdv_axi_req_s axi_req,
  output fpdv_pkg::fpdv_axi_rsp_s axi_rsp,
  output logic busy,
  output logic routine_done,
  output logic interrupt_flag
);

  typedef struct packed {
    fpdv_pkg::fpdv_step_e step;
    logic oor;
    logic [47:0] a;
    logic [47:0] b;
    logic [47:0] mq;
    logic [47:0] cr;
    logic [7:0] e;
    logic [5:0] sc;
    logic zero;
    logic exponent_carry_flag;
    logic sub;
    logic result_sign_flag;
    logic bs;
    logic intr;
    logic done;
    logic [23:0] dvd_frac;
    logic [23:0] dvs_frac;
    logic dvd_sign;
    logic dvs_sign;
    logic [7:0] dvd_exp;
    logic [7:0] dvs_exp;
    logic aw_got;
    logic [4:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fpdv_regs_s;

  fpdv_regs_s s_q;
  fpdv_regs_s s_d;
  logic [5:0] rom_count;
  logic [31:0] wmask;

  ////////////////////////////////////////////////////////////////////////
  // Constant table

  fpdv_const_rom u_rom (
    .aclk(aclk),
    .opcode(fpdv_pkg::OP_SDIV),
    .count(rom_count)
  );

  ////////////////////////////////////////////////////////////////////////
  // Byte-lane mask from the write strobes

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{s_q.wstrb[gi]}};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Bus handshakes and outputs

  assign axi_rsp.awready = !s_q.aw_got && !s_q.bvalid;
  assign axi_rsp.wready = !s_q.w_got && !s_q.bvalid;
  assign axi_rsp.bvalid = s_q.bvalid;
  assign axi_rsp.bresp = s_q.bresp;
  assign axi_rsp.arready = !s_q.rvalid;
  assign axi_rsp.rvalid = s_q.rvalid;
  assign axi_rsp.rdata = s_q.rdata;
  assign axi_rsp.rresp = s_q.rresp;
  assign busy = s_q.step != fpdv_pkg::FPDV_IDLE;
  assign routine_done = s_q.done;
  assign interrupt_flag = s_q.intr;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [31:0] merged;
    logic [4:0] waddr;
    logic [4:0] raddr;
    logic [9:0] ediff;
    logic [8:0] eplus;
    logic [48:0] rem;
    logic qbit;
    logic start;
    merged = 32'h0;
    waddr = 5'h0;
    raddr = 5'h0;
    ediff = 10'h0;
    eplus = 9'h0;
    rem = 49'h0;
    qbit = 1'b0;
    start = 1'b0;
    s_d = s_q;
    s_d.done = 1'b0;

    // Write channel: address and data taken in either order
    if (axi_req.awvalid && !s_q.aw_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s_q.w_got && !s_q.bvalid) begin
      s_d.w_got = 1'b1;
      s_d.wdata = axi_req.wdata;
      s_d.wstrb = axi_req.wstrb;
    end
    if (s_q.aw_got && s_q.w_got) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = fpdv_pkg::RESP_OKAY;
      waddr = {s_q.awaddr[4:2], 2'b00};
      case (waddr)
        fpdv_pkg::OFS_CTRL: begin
          start = s_q.wstrb[0] && s_q.wdata[fpdv_pkg::CTRL_START_BIT];
        end
        fpdv_pkg::OFS_DVD: begin
          merged = (s_q.wdata & wmask) | ({s_q.dvd_sign, 7'h0,
            s_q.dvd_frac} & ~wmask);
          s_d.dvd_sign = merged[fpdv_pkg::OPND_SIGN_BIT];
          s_d.dvd_frac = merged[23:0];
        end
        fpdv_pkg::OFS_DVS: begin
          merged = (s_q.wdata & wmask) | ({s_q.dvs_sign, 7'h0,
            s_q.dvs_frac} & ~wmask);
          s_d.dvs_sign = merged[fpdv_pkg::OPND_SIGN_BIT];
          s_d.dvs_frac = merged[23:0];
        end
        fpdv_pkg::OFS_EXP: begin
          merged = (s_q.wdata & wmask) | ({16'h0, s_q.dvs_exp,
            s_q.dvd_exp} & ~wmask);
          s_d.dvd_exp = merged[7:0];
          s_d.dvs_exp = merged[15:8];
        end
        fpdv_pkg::OFS_STATUS, fpdv_pkg::OFS_RES_HI,
        fpdv_pkg::OFS_RES_LO, fpdv_pkg::OFS_CONST: begin
          s_d.bresp = fpdv_pkg::RESP_OKAY;
        end
        default: s_d.bresp = fpdv_pkg::RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end

    // Read channel
    if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = fpdv_pkg::RESP_OKAY;
      raddr = {axi_req.araddr[4:2], 2'b00};
      case (raddr)
        fpdv_pkg::OFS_CTRL: s_d.rdata = {31'h0, busy};
        fpdv_pkg::OFS_DVD: s_d.rdata = {s_q.dvd_sign, 7'h0, s_q.dvd_frac};
        fpdv_pkg::OFS_DVS: s_d.rdata = {s_q.dvs_sign, 7'h0, s_q.dvs_frac};
        fpdv_pkg::OFS_EXP: s_d.rdata = {16'h0, s_q.dvs_exp, s_q.dvd_exp};
        fpdv_pkg::OFS_STATUS: begin
          s_d.rdata = {16'h0, s_q.e, 1'b0, s_q.oor, s_q.exponent_carry_flag, s_q.zero,
            s_q.result_sign_flag, s_q.intr, 1'b0, busy};
        end
        fpdv_pkg::OFS_RES_HI: s_d.rdata = {8'h0, s_q.a[47:24]};
        fpdv_pkg::OFS_RES_LO: s_d.rdata = {8'h0, s_q.a[23:0]};
        fpdv_pkg::OFS_CONST: s_d.rdata = {8'h0, s_q.cr[47:24]};
        default: begin
          s_d.rdata = 32'h0;
          s_d.rresp = fpdv_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Sequencer
    ediff = {2'b00, s_q.dvd_exp} - {2'b00, s_q.dvs_exp}
      + fpdv_pkg::EXP_BIAS;
    eplus = {1'b0, s_q.e} + 9'h001;
    rem = {1'b0, s_q.a} - {1'b0, s_q.b};
    qbit = s_q.sub && !rem[48];
    case (s_q.step)
      fpdv_pkg::FPDV_IDLE: begin
        if (start) begin
          s_d.a = {s_q.dvd_frac, 24'h0};
          s_d.e = s_q.dvd_exp;
          s_d.result_sign_flag = s_q.dvd_sign;
          s_d.intr = 1'b0;
          s_d.cr = fpdv_pkg::FRAC_ZERO;
          s_d.step = fpdv_pkg::FPDV_EXP;
        end
      end
      fpdv_pkg::FPDV_EXP: begin
        s_d.bs = s_q.dvs_sign;
        s_d.mq = {s_q.dvs_frac, 24'h0};
        s_d.e = ediff[7:0];
        s_d.exponent_carry_flag = ediff[9] || ediff[8];
        s_d.step = fpdv_pkg::FPDV_ZCHK;
      end
      fpdv_pkg::FPDV_ZCHK: begin
        s_d.zero = s_q.a == fpdv_pkg::FRAC_ZERO;
        s_d.oor = s_q.exponent_carry_flag;
        s_d.step = fpdv_pkg::FPDV_MQLD;
      end
      fpdv_pkg::FPDV_MQLD: begin
        s_d.mq = {s_q.mq[47:24], 24'h0};
        s_d.step = s_q.zero ? fpdv_pkg::FPDV_ZD_MOVE
                            : fpdv_pkg::FPDV_SETUP;
      end
      fpdv_pkg::FPDV_SETUP: begin
        s_d.b = s_q.mq;
        s_d.result_sign_flag = s_q.result_sign_flag ^ s_q.bs;
        s_d.sub = 1'b1;
        s_d.sc = rom_count;
        s_d.step = fpdv_pkg::FPDV_LOOP;
      end
      fpdv_pkg::FPDV_LOOP: begin
        s_d.exponent_carry_flag = eplus[8];
        s_d.a = qbit ? {rem[46:0], 1'b0}
                     : {s_q.a[46:0], 1'b0};
        s_d.mq = {s_q.mq[46:24], qbit, 24'h0};
        s_d.sc = s_q.sc - 6'h01;
        if (s_q.sc == 6'h01) begin
          s_d.sub = 1'b0;
          s_d.step = fpdv_pkg::FPDV_COPY;
        end
      end
      fpdv_pkg::FPDV_COPY: begin
        s_d.a = s_q.mq;
        s_d.b = s_q.mq;
        s_d.zero = s_q.b == fpdv_pkg::FRAC_ZERO;
        if (s_q.oor) begin
          s_d.step = s_q.exponent_carry_flag ? fpdv_pkg::FPDV_CUFL7
                              : fpdv_pkg::FPDV_OOR7;
        end else begin
          s_d.step = s_q.exponent_carry_flag ? fpdv_pkg::FPDV_COVF
                              : fpdv_pkg::FPDV_NORM;
        end
      end
      fpdv_pkg::FPDV_NORM: begin
        // Zero flag left untouched here
        s_d.step = (s_q.a[fpdv_pkg::SIGN_POS] || s_q.zero)
          ? fpdv_pkg::FPDV_RSHIFT : fpdv_pkg::FPDV_DONE;
        s_d.done = !(s_q.a[fpdv_pkg::SIGN_POS] || s_q.zero);
      end
      fpdv_pkg::FPDV_COVF: begin
        if (s_q.a[fpdv_pkg::SIGN_POS] || s_q.zero) begin
          s_d.step = fpdv_pkg::FPDV_OFL;
        end else begin
          s_d.step = fpdv_pkg::FPDV_DONE;
          s_d.done = 1'b1;
        end
      end
      fpdv_pkg::FPDV_RSHIFT: begin
        s_d.a = {1'b0, s_q.a[47:1]};
        s_d.b = {1'b0, s_q.b[47:1]};
        s_d.e = eplus[7:0];
        s_d.step = s_q.zero ? fpdv_pkg::FPDV_OFL
                            : fpdv_pkg::FPDV_DONE;
        s_d.done = !s_q.zero;
      end
      fpdv_pkg::FPDV_CUFL7: begin
        s_d.step = (s_q.a[fpdv_pkg::SIGN_POS] || s_q.zero)
          ? fpdv_pkg::FPDV_CUFL8 : fpdv_pkg::FPDV_UFL;
      end
      fpdv_pkg::FPDV_CUFL8: begin
        s_d.a = {1'b0, s_q.a[47:1]};
        s_d.b = {1'b0, s_q.b[47:1]};
        s_d.e = eplus[7:0];
        s_d.step = fpdv_pkg::FPDV_DONE;
        s_d.done = 1'b1;
      end
      fpdv_pkg::FPDV_OOR7: begin
        s_d.cr = fpdv_pkg::CR_TOP;
        s_d.step = s_q.zero ? fpdv_pkg::FPDV_OFL : fpdv_pkg::FPDV_OOR8;
      end
      fpdv_pkg::FPDV_OOR8: begin
        s_d.step = s_q.e[7] ? fpdv_pkg::FPDV_UFL
                            : fpdv_pkg::FPDV_OFL;
      end
      fpdv_pkg::FPDV_OFL: begin
        s_d.a = fpdv_pkg::FRAC_ONES;
        s_d.b = fpdv_pkg::FRAC_ONES;
        s_d.e = fpdv_pkg::EXP_ONES;
        s_d.intr = 1'b1;
        s_d.step = fpdv_pkg::FPDV_DONE;
        s_d.done = 1'b1;
      end
      fpdv_pkg::FPDV_UFL, fpdv_pkg::FPDV_ZRES: begin
        s_d.a = fpdv_pkg::FRAC_ZERO;
        s_d.b = fpdv_pkg::FRAC_ZERO;
        s_d.e = 8'h00;
        s_d.result_sign_flag = 1'b0;
        s_d.intr = s_q.intr || (s_q.step == fpdv_pkg::FPDV_UFL);
        s_d.step = fpdv_pkg::FPDV_DONE;
        s_d.done = 1'b1;
      end
      fpdv_pkg::FPDV_ZD_MOVE: begin
        s_d.b = s_q.mq;
        s_d.step = fpdv_pkg::FPDV_ZD_TEST;
      end
      fpdv_pkg::FPDV_ZD_TEST: begin
        s_d.zero = s_q.b == fpdv_pkg::FRAC_ZERO;
        s_d.step = fpdv_pkg::FPDV_ZD_BR;
      end
      fpdv_pkg::FPDV_ZD_BR: begin
        s_d.cr = fpdv_pkg::CR_TOP;
        s_d.step = s_q.zero ? fpdv_pkg::FPDV_OFL
                            : fpdv_pkg::FPDV_ZRES;
      end
      fpdv_pkg::FPDV_DONE: begin
        s_d.step = fpdv_pkg::FPDV_IDLE;
      end
      default: s_d.step = fpdv_pkg::FPDV_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.step <= fpdv_pkg::FPDV_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : fpdv_top

// ==== src/fpdv_pkg.sv ====
// Package for the single-precision divide sequencer: register map,
// field positions, constant values and counts, sequencer steps and bus carriers.
// Assumes a 32-bit AXI4-Lite master on the register side.
package fpdv_pkg;

  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_DVD = 5'h04;
  localparam logic [4:0] OFS_DVS = 5'h08;
  localparam logic [4:0] OFS_EXP = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_RES_HI = 5'h14;
  localparam logic [4:0] OFS_RES_LO = 5'h18;
  localparam logic [4:0] OFS_CONST = 5'h1c;

  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int OPND_SIGN_BIT = 31;
  localparam int FRAC_W = 24;
  localparam int SIGN_POS = 47;

  // Values and counts
  localparam logic [9:0] EXP_BIAS = 10'h080;
  localparam logic [5:0] CNT_SINGLE = 6'h18;
  localparam logic [5:0] CNT_DOUBLE = 6'h30;
  localparam logic [1:0] OP_SDIV = 2'h0;
  localparam logic [1:0] OP_DDIV = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [47:0] FRAC_ZERO = 48'h0;
  localparam logic [47:0] FRAC_ONES = 48'hffffffffffff;
  localparam logic [47:0] CR_TOP = 48'h800000000000;
  localparam logic [7:0] EXP_ONES = 8'hff;

  typedef enum logic [4:0] {
    FPDV_IDLE, FPDV_EXP, FPDV_ZCHK, FPDV_MQLD, FPDV_SETUP, FPDV_LOOP,
    FPDV_COPY, FPDV_NORM, FPDV_RSHIFT, FPDV_COVF, FPDV_CUFL7, FPDV_CUFL8,
    FPDV_OOR7, FPDV_OOR8, FPDV_OFL, FPDV_UFL, FPDV_ZD_MOVE, FPDV_ZD_TEST,
    FPDV_ZD_BR, FPDV_ZRES, FPDV_DONE
  } fpdv_step_e;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } fpdv_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fpdv_axi_rsp_s;

endpackage : fpdv_pkg

// ==== src/fpdv_const_rom.sv ====
// Opcode-addressed constant table holding iteration counts.
// Read data come out of a register one clock after the address.
`timescale 1ns/1ps
module fpdv_const_rom (
  input wire logic aclk,
  input wire logic [1:0] opcode,
  output logic [5:0] count
);

  always_ff @(posedge aclk) begin
    case (opcode)
      fpdv_pkg::OP_SDIV: count <= fpdv_pkg::CNT_SINGLE;
      fpdv_pkg::OP_DDIV: count <= fpdv_pkg::CNT_DOUBLE;
      default: count <= fpdv_pkg::CNT_SINGLE;
    endcase
  end

endmodule : fpdv_const_rom

// ==== verification/fpdv_top_monitor.sv ====
// Port checks for the divide sequencer.
// Bound onto fpdv_top; sees its ports only.
`timescale 1ns/1ps
module fpdv_top_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire fpdv_pkg::fpdv_axi_req_s axi_req,
  input wire fpdv_pkg::fpdv_axi_rsp_s axi_rsp,
  input wire logic busy,
  input wire logic routine_done,
  input wire logic interrupt_flag
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_start;
    $rose(busy);
  endsequence
  sequence s_run;
    busy [*7];
  endsequence
  property p_min_run;
    s_start |-> s_run;
  endproperty
  property p_done_in;
    s_start |-> ##[7:40] routine_done;
  endproperty
  property p_done_pulse;
    routine_done |=> !routine_done && !busy;
  endproperty
  property p_done_busy;
    routine_done |-> busy;
  endproperty
  property p_irq_fall;
    $fell(interrupt_flag) |-> ##[0:1] busy;
  endproperty
  property p_irq_rise;
    $rose(interrupt_flag) |-> ##[0:1] routine_done;
  endproperty
  property p_r_answer;
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid;
  endproperty
  property p_r_release;
    axi_rsp.rvalid && axi_req.rready && !axi_req.arvalid
      |=> !axi_rsp.rvalid;
  endproperty
  property p_b_answer;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
      |=> ##1 axi_rsp.bvalid;
  endproperty
  a_min_run: assert property (p_min_run)
    else $error("run too short");
  a_done_in: assert property (p_done_in)
    else $error("no completion in time");
  a_done_pulse: assert property (p_done_pulse)
    else $error("completion not a single pulse");
  a_done_busy: assert property (p_done_busy)
    else $error("completion while idle");
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt flag lost while idle");
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt flag not at routine end");
  a_r_answer: assert property (p_r_answer)
    else $error("read answer late");
  a_r_release: assert property (p_r_release)
    else $error("read answer not released");
  a_b_answer: assert property (p_b_answer)
    else $error("write answer late");
endmodule : fpdv_top_monitor

bind fpdv_top fpdv_top_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .busy(busy),
  .routine_done(routine_done), .interrupt_flag(interrupt_flag));

// ==== verification/fpdv_host_model.sv ====
// AXI4-Lite master standing for the processor side.
// Assumes slave outputs settle before the falling edge.
`timescale 1ns/1ps
module fpdv_host_model (
  input wire logic aclk,
  output fpdv_pkg::fpdv_axi_req_s req,
  input wire fpdv_pkg::fpdv_axi_rsp_s rsp
);
  logic hung;
  initial begin
    req = '0;
    hung = 1'b0;
  end
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
    output logic [1:0] r);
    logic ta, tw, tb;
    int n;
    @(posedge aclk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge aclk);
      ta = req.awvalid & rsp.awready;
      tw = req.wvalid & rsp.wready;
      tb = req.bready & rsp.bvalid;
      r = rsp.bresp;
      @(posedge aclk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tb) break;
    end
    req.bready <= 1'b0;
    hung = hung | (n == 100);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d,
    output logic [1:0] r);
    logic ta, tr;
    int n;
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge aclk);
      ta = req.arvalid & rsp.arready;
      tr = req.rready & rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge aclk);
      if (ta) req.arvalid <= 1'b0;
      if (tr) break;
    end
    req.rready <= 1'b0;
    hung = hung | (n == 100);
  endtask : rd
endmodule : fpdv_host_model

// ==== verification/fp_single_divide_sequencer_bench.sv ====
// Self-checking bench for the divide sequencer.
// Assumes the register map of fpdv_pkg and one 100 MHz clock.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    tests_run++; \
    if ((got) !== (ex)) begin \
      n_mismatch++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module fp_single_divide_sequencer_bench;
  typedef struct {
    logic [31:0] dvd;
    logic [31:0] dvs;
    logic [31:0] ex;
    logic [23:0] hi;
    logic [15:0] st;
    int cyc;
  } fpdv_row_s;
  logic aclk, aresetn, busy, routine_done, interrupt_flag;
  fpdv_pkg::fpdv_axi_req_s axi_req;
  fpdv_pkg::fpdv_axi_rsp_s axi_rsp;
  int n_mismatch, tests_run, busy_cnt, n_done;
  logic [31:0] s;
  // Operands, exponents {divisor, dividend}, fraction, status, cycles
  fpdv_row_s rows [12] = '{
    '{32'h007e0000, 32'h00700000, 32'h8183, 24'h480000, 16'h8300, 32},
    '{32'h80200000, 32'h00400000, 32'h8080, 24'h400000, 16'h8008, 31},
    '{32'h0, 32'h00400000, 32'h8080, 24'h0, 16'h0, 0},
    '{32'h0, 32'h0, 32'h8080, 24'hffffff, 16'hff04, 0},
    '{32'h007e0000, 32'h0, 32'h8080, 24'hffffff, 16'hff04, 0},
    '{32'h00400000, 32'h00400000, 32'h00ff, 24'hffffff, 16'hff04, 0},
    '{32'h00400000, 32'h00400000, 32'hff00, 24'h0, 16'h0004, 0},
    '{32'h007e0000, 32'h00700000, 32'h8100, 24'h480000, 16'h0000, 0},
    '{32'h00200000, 32'h00400000, 32'h8100, 24'h0, 16'h0004, 0},
    '{32'h007e0000, 32'h00700000, 32'h80ff, 24'hffffff, 16'hff04, 0},
    '{32'h00200000, 32'h00400000, 32'h80ff, 24'h400000, 16'hff00, 31},
    '{32'h00400000, 32'h0, 32'h00ff, 24'hffffff, 16'hff04, 0}};

  fpdv_top u_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .busy(busy), .routine_done(routine_done),
    .interrupt_flag(interrupt_flag));
  fpdv_host_model u_host (.aclk(aclk), .req(axi_req), .rsp(axi_rsp));

  ////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (busy) busy_cnt <= busy_cnt + 1;
    if (routine_done) n_done <= n_done + 1;
  end

  task automatic print_verdict();
    if (u_host.hung) n_mismatch++;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_host.wr(a, d, r);
    `CHK("bresp", fpdv_pkg::RESP_OKAY, r);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    logic [1:0] r;
    u_host.rd(a, s, r);
    `CHK("rresp", fpdv_pkg::RESP_OKAY, r);
  endtask : rd
  // Loads one table row, starts it and waits for completion
  task automatic go(input int i, input bit twice);
    int k, d0;
    wr(fpdv_pkg::OFS_DVD, rows[i].dvd);
    wr(fpdv_pkg::OFS_DVS, rows[i].dvs);
    wr(fpdv_pkg::OFS_EXP, rows[i].ex);
    busy_cnt = 0;
    d0 = n_done;
    wr(fpdv_pkg::OFS_CTRL, 32'h1);
    if (twice) wr(fpdv_pkg::OFS_CTRL, 32'h1);
    for (k = 0; k < 300 && n_done == d0; k++) @(negedge aclk);
    if (k == 300 || u_host.hung) begin
      n_mismatch++;
      $display("CHECK FAILED routine_done expected 1 seen 0");
      print_verdict();
    end
    @(negedge aclk);
  endtask : go

  ////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    busy_cnt = 0;
    n_done = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK("busy", 1'b0, busy);
    rd(fpdv_pkg::OFS_STATUS);
    `CHK("status", 16'h0, s[15:0]);
    for (int i = 0; i < 12; i++) begin
      go(i, 1'b0);
      rd(fpdv_pkg::OFS_STATUS);
      `CHK("status", rows[i].st, s[15:0] & 16'hff0d);
      rd(fpdv_pkg::OFS_RES_HI);
      `CHK("res_hi", rows[i].hi, s[23:0]);
      `CHK("irq", rows[i].st[2], interrupt_flag);
      if (rows[i].cyc != 0) `CHK("cycles", rows[i].cyc, busy_cnt);
    end
    rd(fpdv_pkg::OFS_CONST);
    `CHK("const", 24'h800000, s[23:0]);
    wr(fpdv_pkg::OFS_STATUS, 32'h0);
    rd(fpdv_pkg::OFS_STATUS);
    `CHK("status ro", 16'hff04, s[15:0] & 16'hff0d);
    // Second start while busy must not restart the count
    go(1, 1'b1);
    `CHK("cycles", 31, busy_cnt);
    `CHK("irq", 1'b0, interrupt_flag);
    // Reset in mid-run
    wr(fpdv_pkg::OFS_CTRL, 32'h1);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK("busy", 1'b0, busy);
    `CHK("done", 1'b0, routine_done);
    print_verdict();
  end
endmodule : fp_single_divide_sequencer_bench
